// ===== tbu_it_params.svh
/*
 Offsets, field positions, widths and reset values of the integration
 register bank. Assumes it is included by bare name wherever needed.
*/
`ifndef TBU_IT_PARAMS_SVH
`define TBU_IT_PARAMS_SVH

// Byte addresses on the register bus
`define OFS_IT_ENABLE 16'h8e20
`define OFS_IT_OUTPUT 16'h8e24
`define OFS_IT_INPUT 16'h8e28
`define OFS_IRQ_STATUS 16'h8e30
`define OFS_IRQ_MASK 16'h8e34
`define OFS_SNP_ADDR_LO 16'h8e38
`define OFS_SNP_ADDR_HI 16'h8e3c
`define OFS_SNP_ATTR 16'h8e40

// Field positions
`define BIT_IT_ENABLE 0
`define BIT_DRV_PMU_IRQ 4
`define BIT_DRV_SNAP_ACK 3
`define BIT_DRV_FAULT_IRQ 2
`define BIT_DRV_ERR_IRQ 1
`define BIT_DRV_CRIT_IRQ 0
`define BIT_IN_SNAP_REQ 0
`define EVT_SNAP_REQ 0
`define EVT_SNOOP 1
`define EVT_BUS_ERR 2
`define SNP_TYPE_LSB 0
`define SNP_PROT_LSB 4

// Widths
`define DRV_WIDTH 5
`define EVT_WIDTH 3
`define SNP_ADDR_W 52
`define SNP_TYPE_W 4
`define SNP_PROT_W 3
`define APB_ADDR_W 16

// Reset values
`define RST_IT_ENABLE 1'h0
`define RST_IT_OUTPUT 5'h00
`define RST_IRQ_STATUS 3'h0
`define RST_IRQ_MASK 3'h0

`endif

// ===== tbu_it_pkg.sv
/*
 Types shared by the integration register bank and its two helpers.
 Assumes tbu_it_params.svh is reachable on the include path.
*/
package tbu_it_pkg;
`include "tbu_it_params.svh"

   typedef enum logic [0:0] {
      SNP_READY = 1'b0,
      SNP_HELD = 1'b1
   } snoop_state_e;

   typedef struct packed {
      logic [1:0] stage;
   } sync_s;

   typedef struct packed {
      snoop_state_e state;
      logic taken;
      logic [`SNP_ADDR_W-1:0] addr;
      logic [`SNP_TYPE_W-1:0] kind;
      logic [`SNP_PROT_W-1:0] prot;
   } snoop_s;

   typedef struct packed {
      logic itEnable;
      logic [`DRV_WIDTH-1:0] itDrive;
      logic [`EVT_WIDTH-1:0] irqStatus;
      logic [`EVT_WIDTH-1:0] irqMask;
      logic snapPrev;
      logic irq;
      logic [31:0] prdata;
      logic pslverr;
   } regs_s;
endpackage

// ===== bit_sync.sv
/*
 Two-stage synchroniser for one level from outside the clock domain.
 Assumes the input is a level that stays put for several clocks.
*/
`timescale 1ns/10ps
module bit_sync
   import tbu_it_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic asyncIn,
   output logic syncOut
);
   sync_s q_q;
   sync_s q_d;

   // First stage feeds only the second stage
   always_comb begin
      q_d = q_q;
      q_d.stage = {q_q.stage[0], asyncIn};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   assign syncOut = q_q.stage[1];
endmodule

// ===== snoop_sink.sv
/*
 Accepts the snoop address channel of the walk and snoop interface and
 holds the last snoop taken. Assumes the sender follows valid/ready rules.
*/
`timescale 1ns/10ps
`include "tbu_it_params.svh"
module snoop_sink
   import tbu_it_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic acvalid,
   output logic acready,
   input wire logic [`SNP_ADDR_W-1:0] acaddr,
   input wire logic [`SNP_TYPE_W-1:0] acsnoop,
   input wire logic [`SNP_PROT_W-1:0] acprot,
   output logic snoopTaken,
   output logic [`SNP_ADDR_W-1:0] snoopAddr,
   output logic [`SNP_TYPE_W-1:0] snoopType,
   output logic [`SNP_PROT_W-1:0] snoopProt
);
   snoop_s s_q;
   snoop_s s_d;
   logic handshake;

   assign acready = (s_q.state == SNP_READY);
   assign handshake = acvalid && acready;

   // One hold cycle after each snoop gives the consumer time to see it
   always_comb begin
      s_d = s_q;
      s_d.taken = 1'b0;
      case (s_q.state)
         SNP_READY: begin
            if (handshake) begin
               s_d.addr = acaddr;
               s_d.kind = acsnoop;
               s_d.prot = acprot;
               s_d.taken = 1'b1;
               s_d.state = SNP_HELD;
            end
         end
         SNP_HELD: s_d.state = SNP_READY;
         default: s_d.state = SNP_READY;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign snoopTaken = s_q.taken;
   assign snoopAddr = s_q.addr;
   assign snoopType = s_q.kind;
   assign snoopProt = s_q.prot;

   a_snoop_capture: assert property (@(posedge clock) disable iff (rst)
      handshake |=> snoopTaken && snoopAddr == $past(acaddr)
      && snoopType == $past(acsnoop) && snoopProt == $past(acprot))
      else $error("snoop fields not captured");
   a_snoop_hold: assert property (@(posedge clock) disable iff (rst)
      handshake |=> !acready ##1 acready)
      else $error("snoop ready not held low for one cycle");
endmodule

// ===== tbu_integration_regs.sv
/*
 Integration-test register bank of the translation buffer unit, an APB
 slave. In integration mode software drives the interrupt and snapshot
 acknowledge outputs and reads the snapshot request input; otherwise the
 functional logic drives them. Assumes the functional inputs come from
 logic on the same clock and the snapshot request may come from outside.
*/
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "tbu_it_params.svh"
module tbu_integration_regs
   import tbu_it_pkg::*;
#(
   parameter int PADDR_W = `APB_ADDR_W
)(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic funcPmuIrq,
   input wire logic funcSnapAck,
   input wire logic funcFaultIrq,
   input wire logic funcErrIrq,
   input wire logic funcCritIrq,
   output logic pmuIrq,
   output logic snapAck,
   output logic faultIrq,
   output logic errIrq,
   output logic critIrq,
   input wire logic snapReq,
   output logic snapReqSync,
   input wire logic acvalid,
   output logic acready,
   input wire logic [`SNP_ADDR_W-1:0] acaddr,
   input wire logic [`SNP_TYPE_W-1:0] acsnoop,
   input wire logic [`SNP_PROT_W-1:0] acprot,
   output logic snoopTaken,
   output logic [`SNP_ADDR_W-1:0] snoopAddr,
   output logic [`SNP_TYPE_W-1:0] snoopType,
   output logic [`SNP_PROT_W-1:0] snoopProt,
   output logic blockIrq
);
   // Offsets need 16 address bits; the bus carries no more than 32
   // On a wider bus the upper address bits must be zero to hit a register
   generate
      if (PADDR_W < 16 || PADDR_W > 32) begin : g_bad_width
         $error("PADDR_W must lie between 16 and 32");
      end
   endgenerate

   // All bank state sits in one struct; r_d is its next value
   regs_s r_q;
   regs_s r_d;
   logic setup;
   logic access;
   logic wrAcc;
   logic hit;
   logic [31:0] rdMux;
   logic [`DRV_WIDTH-1:0] funcVec;
   logic [`DRV_WIDTH-1:0] outVec;
   logic [`EVT_WIDTH-1:0] events;
   logic sampledIn;
   logic [PADDR_W-1:0] addr;

   // Snapshot request may arrive from another block's timing
   bit_sync u_snap_sync (
      .clock(clock),
      .rst(rst),
      .asyncIn(snapReq),
      .syncOut(snapReqSync)
   );

   // Snoops are accepted and recorded; this block sends no snoop response
   snoop_sink u_snoop (
      .clock(clock),
      .rst(rst),
      .acvalid(acvalid),
      .acready(acready),
      .acaddr(acaddr),
      .acsnoop(acsnoop),
      .acprot(acprot),
      .snoopTaken(snoopTaken),
      .snoopAddr(snoopAddr),
      .snoopType(snoopType),
      .snoopProt(snoopProt)
   );

   // Bus phases; pprot is accepted but grants no extra privilege
   assign addr = paddr;
   assign setup = psel && !penable;
   assign access = psel && penable;
   // Writes are dropped after an error so an unmapped offset changes only the bus error status bit
   assign wrAcc = access && pwrite && !r_q.pslverr;
   // No wait states: read data and error are already latched in setup
   assign pready = 1'b1;

   // Integration input reads zero outside integration mode
   assign sampledIn = r_q.itEnable && snapReqSync;

   // Address decode and read data, latched in the setup cycle
   // Reserved bits read zero; an unmapped offset clears hit and flags an error
   always_comb begin
      hit = 1'b1;
      rdMux = 32'h0000_0000;
      case (addr)
         PADDR_W'(`OFS_IT_ENABLE): rdMux[`BIT_IT_ENABLE] = r_q.itEnable;
         PADDR_W'(`OFS_IT_OUTPUT): rdMux[`DRV_WIDTH-1:0] = r_q.itDrive;
         PADDR_W'(`OFS_IT_INPUT): rdMux[`BIT_IN_SNAP_REQ] = sampledIn;
         PADDR_W'(`OFS_IRQ_STATUS): rdMux[`EVT_WIDTH-1:0] = r_q.irqStatus;
         PADDR_W'(`OFS_IRQ_MASK): rdMux[`EVT_WIDTH-1:0] = r_q.irqMask;
         PADDR_W'(`OFS_SNP_ADDR_LO): rdMux = snoopAddr[31:0];
         PADDR_W'(`OFS_SNP_ADDR_HI): rdMux[`SNP_ADDR_W-33:0] = snoopAddr[`SNP_ADDR_W-1:32];
         PADDR_W'(`OFS_SNP_ATTR): begin
            rdMux[`SNP_TYPE_LSB +: `SNP_TYPE_W] = snoopType;
            rdMux[`SNP_PROT_LSB +: `SNP_PROT_W] = snoopProt;
         end
         default: hit = 1'b0;
      endcase
   end

   // Events: snapshot request rise, snoop taken, bus error
   assign events[`EVT_SNAP_REQ] = snapReqSync && !r_q.snapPrev;
   assign events[`EVT_SNOOP] = snoopTaken;
   assign events[`EVT_BUS_ERR] = access && r_q.pslverr;

   // Register bank next state
   // Writes need byte lane 0 because every writable field sits in the low byte
   always_comb begin
      r_d = r_q;
      // Previous synchronised level feeds the rise detector
      r_d.snapPrev = snapReqSync;
      // Read data and error are fixed in setup and stand through access
      if (setup) begin
         r_d.prdata = pwrite ? 32'h0000_0000 : rdMux;
         r_d.pslverr = !hit;
      end
      if (wrAcc && pstrb[0]) begin
         case (addr)
            PADDR_W'(`OFS_IT_ENABLE): begin
               r_d.itEnable = pwdata[`BIT_IT_ENABLE];
            end
            PADDR_W'(`OFS_IT_OUTPUT): begin
               // Bits above the drive field are dropped as software must leave them zero
               r_d.itDrive = pwdata[`DRV_WIDTH-1:0];
            end
            PADDR_W'(`OFS_IRQ_STATUS): begin
               r_d.irqStatus = r_q.irqStatus & ~pwdata[`EVT_WIDTH-1:0];
            end
            PADDR_W'(`OFS_IRQ_MASK): r_d.irqMask = pwdata[`EVT_WIDTH-1:0];
            default: r_d.irqMask = r_q.irqMask;
         endcase
      end
      // A new event wins over a write-one-to-clear in the same cycle
      r_d.irqStatus = r_d.irqStatus | events;
      r_d.irq = |(r_d.irqStatus & r_d.irqMask);
   end

   // The only clock and the only reset of the bank
   // Reset leaves the bank in functional mode with no event pending
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_q <= '0;
         r_q.itEnable <= `RST_IT_ENABLE;
         r_q.itDrive <= `RST_IT_OUTPUT;
         r_q.irqStatus <= `RST_IRQ_STATUS;
         r_q.irqMask <= `RST_IRQ_MASK;
      end else begin
         r_q <= r_d;
      end
   end

   // Output steering is kept combinational so functional interrupts add no latency
   // Drive bits written while the mode is off are kept but have no effect
   assign funcVec = {funcPmuIrq, funcSnapAck, funcFaultIrq, funcErrIrq, funcCritIrq};
   assign outVec = r_q.itEnable ? r_q.itDrive : funcVec;
   assign pmuIrq = outVec[`BIT_DRV_PMU_IRQ];
   assign snapAck = outVec[`BIT_DRV_SNAP_ACK];
   assign faultIrq = outVec[`BIT_DRV_FAULT_IRQ];
   assign errIrq = outVec[`BIT_DRV_ERR_IRQ];
   assign critIrq = outVec[`BIT_DRV_CRIT_IRQ];

   // Bus answers and the interrupt come straight from flops
   assign prdata = r_q.prdata;
   assign pslverr = r_q.pslverr;
   assign blockIrq = r_q.irq;

   // Checks on the bank
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic wrEn;
   logic wrOut;
   logic rdIn;
   logic rdEn;
   logic rdOut;
   logic wrStatus;
   logic wrMask;
   // Decoded strobes used only by the checks below
   assign wrEn = wrAcc && pstrb[0] && addr == PADDR_W'(`OFS_IT_ENABLE);
   assign wrOut = wrAcc && pstrb[0] && addr == PADDR_W'(`OFS_IT_OUTPUT);
   assign rdIn = setup && !pwrite && addr == PADDR_W'(`OFS_IT_INPUT);
   assign rdEn = setup && !pwrite && addr == PADDR_W'(`OFS_IT_ENABLE);
   assign rdOut = setup && !pwrite && addr == PADDR_W'(`OFS_IT_OUTPUT);
   assign wrStatus = wrAcc && pstrb[0] && addr == PADDR_W'(`OFS_IRQ_STATUS);
   assign wrMask = wrAcc && pstrb[0] && addr == PADDR_W'(`OFS_IRQ_MASK);

   // A write lands at the access edge and shows one cycle later
   a_enable_write: assert property (wrEn |=> r_q.itEnable == $past(pwdata[0]))
      else $error("integration enable not updated");
   a_pmu_drive: assert property (wrOut && r_q.itEnable |=> pmuIrq == $past(pwdata[4]))
      else $error("performance interrupt not driven from register");
   a_ack_drive: assert property (wrOut && r_q.itEnable |=> snapAck == $past(pwdata[3]))
      else $error("snapshot acknowledge not driven from register");
   a_fault_drive: assert property (wrOut && r_q.itEnable |=> faultIrq == $past(pwdata[2]))
      else $error("fault interrupt not driven from register");
   a_err_drive: assert property (wrOut && r_q.itEnable |=> errIrq == $past(pwdata[1]))
      else $error("error interrupt not driven from register");
   a_crit_drive: assert property (wrOut && r_q.itEnable |=> critIrq == $past(pwdata[0]))
      else $error("critical interrupt not driven from register");
   // The input register reads the synchronised level, never the raw pin
   a_input_read: assert property (rdIn && r_q.itEnable |=>
      prdata == {31'h0, $past(snapReqSync)})
      else $error("input register does not show snapshot request");
   a_input_zero: assert property (rdIn && !r_q.itEnable |=> prdata == 32'h0)
      else $error("input register not zero outside integration mode");
   a_func_path: assert property (!r_q.itEnable && $changed(funcPmuIrq) |->
      pmuIrq == funcPmuIrq)
      else $error("functional interrupt not passed through");
   // Reset must leave integration mode off and the drive cleared
   a_reset_clear: assert property ($past(rst) |-> !r_q.itEnable && r_q.itDrive == '0)
      else $error("integration registers not cleared by reset");
   // Snoop arrivals are recorded even while the mask hides them
   a_event_sticky: assert property (snoopTaken |=> r_q.irqStatus[`EVT_SNOOP])
      else $error("snoop event not recorded");

   // Unmapped offsets answer with an error and zero read data
   a_unmapped_error: assert property (setup && !hit |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped offset did not flag an error");
   a_read_clean: assert property (setup && hit |=> !pslverr)
      else $error("mapped offset flagged an error");
   // An errored access must leave the enable, drive and mask registers alone
   a_error_no_write: assert property (access && pslverr |=>
      $stable(r_q.itEnable) && $stable(r_q.itDrive) && $stable(r_q.irqMask))
      else $error("errored access changed a register");

   // Reserved bits of the enable and drive registers read zero
   a_enable_reserved: assert property (rdEn |=> prdata[31:1] == '0)
      else $error("reserved enable bits not zero");
   a_drive_reserved: assert property (rdOut |=> prdata[31:`DRV_WIDTH] == '0)
      else $error("reserved drive bits not zero");

   // Output steering in both modes, checked every cycle
   a_dormant_outputs: assert property (!r_q.itEnable |->
      {pmuIrq, snapAck, faultIrq, errIrq, critIrq}
      == {funcPmuIrq, funcSnapAck, funcFaultIrq, funcErrIrq, funcCritIrq})
      else $error("functional levels not passed through");
   a_active_outputs: assert property (r_q.itEnable |->
      {pmuIrq, snapAck, faultIrq, errIrq, critIrq} == r_q.itDrive)
      else $error("outputs not driven from the drive register");

   // Status bits are sticky: they move only on an event or a clearing write
   a_status_hold: assert property (events == '0 && !wrStatus |=>
      r_q.irqStatus == $past(r_q.irqStatus))
      else $error("status changed without event or clear");
   a_status_clear: assert property (wrStatus && events == '0 |=>
      r_q.irqStatus == ($past(r_q.irqStatus) & ~$past(pwdata[`EVT_WIDTH-1:0])))
      else $error("status bits not cleared by writing one");
   a_error_sticky: assert property (events[`EVT_BUS_ERR] |=> r_q.irqStatus[`EVT_BUS_ERR])
      else $error("bus error event not recorded");
   a_snap_sticky: assert property (snapReqSync && !r_q.snapPrev |=>
      r_q.irqStatus[`EVT_SNAP_REQ])
      else $error("snapshot request rise not recorded");
   // A mask write reaches the interrupt output in the next cycle
   a_mask_irq: assert property (wrMask |=>
      blockIrq == |(r_q.irqStatus & $past(pwdata[`EVT_WIDTH-1:0])))
      else $error("interrupt output does not follow the mask");

   // Scenarios the bench is expected to reach
   c_drive_in_mode: cover property (wrEn && pwdata[0] ##[1:20] wrOut);
   c_input_sampled: cover property (rdIn && r_q.itEnable && snapReqSync);
   c_snoop_taken: cover property (snoopTaken && blockIrq);
   c_bus_error: cover property (access && pslverr);
endmodule

// ===== far_side_model.sv
/*
 Far-side model: snapshot request source and snoop address sender.
 Assumes one clock shared with the register bank and commands from the bench.
*/
`timescale 1ns/10ps
`include "tbu_it_params.svh"
module far_side_model
   import tbu_it_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reqLevel,
   input wire logic send,
   input wire logic [`SNP_ADDR_W-1:0] addr,
   input wire logic [`SNP_TYPE_W-1:0] kind,
   input wire logic [`SNP_PROT_W-1:0] prot,
   input wire logic acready,
   output logic acvalid,
   output logic [`SNP_ADDR_W-1:0] acaddr,
   output logic [`SNP_TYPE_W-1:0] acsnoop,
   output logic [`SNP_PROT_W-1:0] acprot,
   output logic snapReq
);
   // Single clock and reset drive all far-side state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acvalid <= 1'b0;
         acaddr <= '0;
         acsnoop <= '0;
         acprot <= '0;
         snapReq <= 1'b0;
      end else begin
         snapReq <= reqLevel;
         if (acvalid && acready) begin
            // Released fields flip so a late sample cannot match by luck
            acvalid <= 1'b0;
            acaddr <= ~acaddr;
            acsnoop <= ~acsnoop;
            acprot <= ~acprot;
         end else if (send && !acvalid) begin
            // Held unchanged until the handshake edge
            acvalid <= 1'b1;
            acaddr <= addr;
            acsnoop <= kind;
            acprot <= prot;
         end
      end
   end
endmodule

// ===== tb_top.sv
/*
 Self-checking bench of the integration register bank over APB.
 Assumes the design files and far_side_model are compiled first.
*/
`timescale 1ns/10ps
`include "tbu_it_params.svh"
module tb_top;
   localparam logic [51:0] SADDR = 52'h9_a5c3_1e7b_4d26;
   localparam logic [3:0] SKIND = 4'hb;
   localparam logic [2:0] SPROT = 3'h5;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, send, reqLevel, atEdge;
   logic snapReq, snapReqSync, acvalid, acready, snoopTaken, blockIrq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [4:0] func, outs;
   logic [51:0] acaddr, snoopAddr;
   logic [3:0] acsnoop, snoopType;
   logic [2:0] acprot, snoopProt;
   logic e;
   int errCount, nTests, n;

   tbu_integration_regs dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pprot(3'h0),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .funcPmuIrq(func[4]),
      .funcSnapAck(func[3]), .funcFaultIrq(func[2]), .funcErrIrq(func[1]),
      .funcCritIrq(func[0]), .pmuIrq(outs[4]), .snapAck(outs[3]), .faultIrq(outs[2]),
      .errIrq(outs[1]), .critIrq(outs[0]), .snapReq(snapReq), .snapReqSync(snapReqSync),
      .acvalid(acvalid), .acready(acready), .acaddr(acaddr), .acsnoop(acsnoop),
      .acprot(acprot), .snoopTaken(snoopTaken), .snoopAddr(snoopAddr),
      .snoopType(snoopType), .snoopProt(snoopProt), .blockIrq(blockIrq));

   far_side_model far_u (.clock(clock), .rst(rst), .reqLevel(reqLevel), .send(send),
      .addr(SADDR), .kind(SKIND), .prot(SPROT), .acready(acready), .acvalid(acvalid),
      .acaddr(acaddr), .acsnoop(acsnoop), .acprot(acprot), .snapReq(snapReq));

   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      nTests++;
      if (got !== ex) begin
         errCount++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One APB transfer; the request stays put until pready is seen high
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      k = 0;
      if (!atEdge) @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clock);
      end
      if (pready !== 1'b1) begin
         errCount++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      atEdge = 1'b1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] ex,
      input logic xe);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, r);
      chk("slave error", 32'(xe), 32'(e));
   endtask

   // Leaves the bus idle and stops at a falling edge where outputs are settled
   task automatic idle();
      if (atEdge) begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
      repeat (2) @(posedge clock);
      @(negedge clock);
      atEdge = 1'b0;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      send = 1'b0;
      reqLevel = 1'b0;
      atEdge = 1'b0;
      func = 5'h15;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rd("enable", `OFS_IT_ENABLE, 32'h0, 1'b0);
      rd("drive", `OFS_IT_OUTPUT, 32'h0, 1'b0);
      rd("input", `OFS_IT_INPUT, 32'h0, 1'b0);
      idle();
      chk("outputs", 32'h15, 32'(outs));
      $display("test reset done");
      @(posedge clock);
      reqLevel <= 1'b1;
      func <= 5'h0a;
      idle();
      idle();
      chk("sync", 32'h1, 32'(snapReqSync));
      rd("input off", `OFS_IT_INPUT, 32'h0, 1'b0);
      idle();
      chk("outputs", 32'h0a, 32'(outs));
      $display("test functional mode done");
      wr(`OFS_IT_ENABLE, 32'h1);
      rd("enable", `OFS_IT_ENABLE, 32'h1, 1'b0);
      rd("input on", `OFS_IT_INPUT, 32'h1, 1'b0);
      // Functional inputs set opposite to the drive so a wrong mux shows
      for (int i = 0; i < 5; i++) begin
         wr(`OFS_IT_OUTPUT, 32'h1 << i);
         func <= ~(5'h1 << i);
         rd("drive", `OFS_IT_OUTPUT, 32'h1 << i, 1'b0);
         idle();
         chk("outputs", 32'h1 << i, 32'(outs));
      end
      @(posedge clock);
      reqLevel <= 1'b0;
      idle();
      idle();
      chk("sync", 32'h0, 32'(snapReqSync));
      rd("input on", `OFS_IT_INPUT, 32'h0, 1'b0);
      wr(`OFS_IT_OUTPUT, 32'h0);
      wr(`OFS_IT_ENABLE, 32'h0);
      func <= 5'h13;
      idle();
      chk("outputs", 32'h13, 32'(outs));
      $display("test integration mode done");
      rd("status", `OFS_IRQ_STATUS, 32'h1, 1'b0);
      chk("irq masked", 32'h0, 32'(blockIrq));
      wr(`OFS_IRQ_MASK, 32'h7);
      idle();
      chk("irq raised", 32'h1, 32'(blockIrq));
      rd("unmapped", 16'h8e50, 32'h0, 1'b1);
      idle();
      rd("status", `OFS_IRQ_STATUS, 32'h5, 1'b0);
      wr(`OFS_IRQ_STATUS, 32'h5);
      idle();
      chk("irq cleared", 32'h0, 32'(blockIrq));
      $display("test interrupt done");
      @(posedge clock);
      send <= 1'b1;
      @(posedge clock);
      send <= 1'b0;
      n = 0;
      while (snoopTaken !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      if (snoopTaken !== 1'b1) begin
         errCount++;
         summarize();
      end
      chk("acready held", 32'h0, 32'(acready));
      chk("snoop lo", SADDR[31:0], snoopAddr[31:0]);
      chk("snoop hi", 32'(SADDR[51:32]), 32'(snoopAddr[51:32]));
      chk("snoop attr", 32'({SPROT, SKIND}), 32'({snoopProt, snoopType}));
      rd("addr lo", `OFS_SNP_ADDR_LO, SADDR[31:0], 1'b0);
      rd("addr hi", `OFS_SNP_ADDR_HI, 32'(SADDR[51:32]), 1'b0);
      rd("attr", `OFS_SNP_ATTR, 32'({SPROT, SKIND}), 1'b0);
      rd("status", `OFS_IRQ_STATUS, 32'h2, 1'b0);
      $display("test snoop done");
      wr(`OFS_IT_ENABLE, 32'h1);
      wr(`OFS_IT_OUTPUT, 32'h1f);
      idle();
      chk("outputs", 32'h1f, 32'(outs));
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd("enable", `OFS_IT_ENABLE, 32'h0, 1'b0);
      rd("drive", `OFS_IT_OUTPUT, 32'h0, 1'b0);
      idle();
      chk("outputs", 32'h13, 32'(outs));
      $display("test mid-run reset done");
      summarize();
   end
endmodule
